// ==== include/fsmon_pkg.sv ====
package fsmon_pkg;
  // register indices; byte address is index times four
  localparam int AXI_AW = 12;
  localparam logic [9:0] IDX_CLEAR = 10'h003;
  localparam logic [9:0] IDX_PD_STATUS = 10'h021;
  localparam logic [9:0] IDX_STATUS = 10'h078;
  localparam logic [9:0] IDX_CTRL = 10'h0e0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status byte fields
  localparam int ST_BUSY = 7;
  localparam int ST_OFF = 6;
  localparam int ST_LAT_LO = 1;
  localparam int ST_LAT_HI = 5;
  // control fields
  localparam int CTL_INT_MODE = 0;
  localparam int CTL_HICCUP = 1;
  localparam int CTL_SECOND_OVERVOLTAGE_LEVEL_EN = 2;
  localparam int CTL_IVP_EN = 3;
  localparam int CTL_IVR_EN = 4;
  localparam int CTL_AVG_EN = 5;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // asynchronous input positions
  localparam int IN_PG = 0;
  localparam int IN_SYS_OFF = 1;
  localparam int IN_FIRST_OVERVOLTAGE_LEVEL = 2;
  localparam int IN_SECOND_OVERVOLTAGE_LEVEL = 3;
  localparam int IN_PEAK = 4;
  localparam int IN_VIN_LOW = 5;
  localparam int IN_TSD = 6;
  localparam int IN_TWARN = 7;
  localparam int IN_AVG = 8;
  localparam int IN_VIN_HIGH = 9;
  localparam int IN_BOOTSTRAP_UNDERVOLTAGE = 10;
  localparam int IN_MODE = 11;
  localparam int IN_SWCLK = 12;
  localparam int IN_W = 13;
  // timing
  localparam int CLK_NS = 40;
  localparam int HICCUP_OFF_NS = 2000;
  localparam int HICCUP_OFF_CYC = (HICCUP_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIC_CW = 6;
  localparam logic [3:0] BOOT_STOP_CYC = 4'h8;
  localparam logic [3:0] BOOT_REFRESH_CYC = 4'h4;
  typedef enum logic {HIC_RUN, HIC_OFF} fsmon_hic_t;
endpackage

// ==== hdl/fsmon_sync.sv ====
`timescale 1ns/10ps
module fsmon_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else if (clk_en) begin
          meta_r <= din[i];
          hold_r <= meta_r;
        end
      end
      assign dout[i] = hold_r;
    end
  endgenerate
endmodule

// ==== hdl/fsmon_core.sv ====
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module fsmon_core (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [fsmon_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fsmon_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pg_above,
  input wire logic system_off,
  input wire logic first_overvoltage_level,
  input wire logic second_overvoltage_level,
  input wire logic peak_limit_event,
  input wire logic input_level_low,
  input wire logic thermal_shutdown,
  input wire logic thermal_warning,
  input wire logic avg_limit_reached,
  input wire logic input_protection_trip,
  input wire logic bootstrap_undervoltage,
  input wire logic mode_pin,
  input wire logic switch_clk,
  input wire logic startup_done,
  input wire logic field_busy,
  input wire logic soft_start_done,
  input wire logic micro_sleep,
  input wire logic internal_fb_sel,
  input wire logic nvm_boot_done,
  input wire logic [7:0] crc_computed,
  input wire logic [7:0] crc_stored,
  output logic fault_interrupt_pin_o,
  output logic fault_interrupt_pin_oe,
  output logic converter_enable,
  output logic power_stage_hiz,
  output logic forced_pulse_allow,
  output logic forward_only,
  output logic input_regulation_active,
  output logic boot_refresh,
  output logic power_good_mon,
  output logic hiccup_restart
);
  import fsmon_pkg::*;

  logic [IN_W-1:0] raw;
  logic [IN_W-1:0] syn;
  assign raw = {switch_clk, mode_pin, bootstrap_undervoltage, input_protection_trip,
                avg_limit_reached, thermal_warning, thermal_shutdown, input_level_low,
                peak_limit_event, second_overvoltage_level, first_overvoltage_level,
                system_off, pg_above};

  fsmon_sync #(.W(IN_W)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .din(raw),
    .dout(syn)
  );

  logic [7:0] ctrl_r;
  logic [4:0] lat_r;
  logic [6:0] live_prev_r;
  logic any_prev_r;
  logic flt_ind_r;
  logic tog_r;
  logic sw_prev_r;
  logic crc_fail_r;
  logic [3:0] boot_cnt_r;
  logic [HIC_CW-1:0] hic_cnt_r;
  fsmon_hic_t hic_r;
  logic aw_got_r;
  logic w_got_r;
  logic [9:0] aw_idx_r;
  logic [7:0] wd_r;
  logic wstb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic conv_en_r;
  logic hiz_r;
  logic forced_pulse_mode_r;
  logic fwd_r;
  logic ivr_r;
  logic refresh_r;
  logic pg_r;
  logic restart_r;

  // live condition decode
  wire int_mode = ctrl_r[CTL_INT_MODE];
  wire forced_pulse_mode_mode = syn[IN_MODE];
  wire first_overvoltage_level_ev = syn[IN_FIRST_OVERVOLTAGE_LEVEL] & soft_start_done & ~internal_fb_sel & ~micro_sleep;
  wire second_overvoltage_level_ev = syn[IN_SECOND_OVERVOLTAGE_LEVEL] & ctrl_r[CTL_SECOND_OVERVOLTAGE_LEVEL_EN];
  wire out_ev = first_overvoltage_level_ev | second_overvoltage_level_ev;
  wire cur_ev = syn[IN_PEAK];
  wire in_ev = syn[IN_VIN_LOW];
  wire temp_ev = syn[IN_TSD] | syn[IN_TWARN];
  wire crc_bad = nvm_boot_done & (crc_computed != crc_stored);
  wire ilf_ev = crc_bad | crc_fail_r;
  wire [4:0] ev = {out_ev, cur_ev, in_ev, temp_ev, ilf_ev};
  wire off_live = ~syn[IN_PG] | syn[IN_SYS_OFF];
  wire avg_flag = ctrl_r[CTL_AVG_EN] & syn[IN_AVG];
  wire [6:0] live = {off_live, ev, avg_flag};
  wire any_fault = |ev;

  // register bus decode
  wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  wire wr_clear = wr_fire & (aw_idx_r == IDX_CLEAR);
  wire wr_status = wr_fire & (aw_idx_r == IDX_STATUS) & wstb_r;
  wire wr_ctrl = wr_fire & (aw_idx_r == IDX_CTRL) & wstb_r;
  wire wr_ok = (aw_idx_r == IDX_CLEAR) | (aw_idx_r == IDX_STATUS) | (aw_idx_r == IDX_CTRL)
               | (aw_idx_r == IDX_PD_STATUS);
  wire rd_fire = s_axi_arvalid & ~rvalid_r;
  wire [9:0] ar_idx = s_axi_araddr[AXI_AW-1:2];
  wire rd_clear = rd_fire & (ar_idx == IDX_CLEAR);
  wire [7:0] status_rd = {field_busy & startup_done, off_live & startup_done, lat_r,
                          1'b0};
  wire [7:0] pd_rd = {7'h00, avg_flag};
  wire rd_hit = (ar_idx == IDX_CLEAR) | (ar_idx == IDX_STATUS) | (ar_idx == IDX_CTRL)
                | (ar_idx == IDX_PD_STATUS);
  wire [7:0] rd_byte = (ar_idx == IDX_STATUS) ? status_rd :
                       (ar_idx == IDX_PD_STATUS) ? pd_rd :
                       (ar_idx == IDX_CTRL) ? ctrl_r : 8'h00;

  // sticky faults: a new event wins over any clear in the same cycle
  wire clr_all = wr_clear | rd_clear;
  wire [4:0] clr = {5{clr_all}} | ({5{wr_status}} & wd_r[ST_LAT_HI:ST_LAT_LO]);
  wire [4:0] lat_nxt = ev | (lat_r & ~clr);

  // pin behaviour
  wire live_change = |(live ^ live_prev_r);
  wire tog_nxt = tog_r ^ (int_mode & live_change);
  wire flt_nxt = (any_fault & ~any_prev_r)
                 | (flt_ind_r & any_fault & ~restart_r);

  // bootstrap undervoltage counting on switching edges
  wire sw_rise = syn[IN_SWCLK] & ~sw_prev_r;
  wire [3:0] boot_lim = forced_pulse_mode_mode ? BOOT_STOP_CYC : BOOT_REFRESH_CYC;
  wire boot_stop = syn[IN_BOOTSTRAP_UNDERVOLTAGE] & (boot_cnt_r >= boot_lim);
  wire [3:0] boot_nxt = ~syn[IN_BOOTSTRAP_UNDERVOLTAGE] ? 4'h0 :
                        (sw_rise & ~boot_stop) ? boot_cnt_r + 4'h1 : boot_cnt_r;

  // hiccup sequencing
  wire hic_start = (hic_r == HIC_RUN) & ctrl_r[CTL_HICCUP] & cur_ev;
  wire hic_done = (hic_r == HIC_OFF) & (hic_cnt_r == HIC_CW'(HICCUP_OFF_CYC - 1));
  fsmon_hic_t hic_nxt;
  always_comb begin
    case (hic_r)
      HIC_RUN: hic_nxt = hic_start ? HIC_OFF : HIC_RUN;
      HIC_OFF: hic_nxt = hic_done ? HIC_RUN : HIC_OFF;
      default: hic_nxt = HIC_RUN;
    endcase
  end

  // converter reactions
  wire ivp_susp = ctrl_r[CTL_IVP_EN] & syn[IN_VIN_HIGH];
  wire conv_nxt = ~syn[IN_TSD] & ~crc_fail_r & ~crc_bad & (hic_r == HIC_RUN) & ~hic_start
                  & ~boot_stop & ~syn[IN_SYS_OFF];
  wire ivr_nxt = ctrl_r[CTL_IVP_EN] & ctrl_r[CTL_IVR_EN] & forced_pulse_mode_mode;
  wire refresh_nxt = syn[IN_BOOTSTRAP_UNDERVOLTAGE] & ~forced_pulse_mode_mode & ~boot_stop;
  wire pg_nxt = syn[IN_PG] & soft_start_done;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CTRL_RESET;
      lat_r <= STATUS_RESET[ST_LAT_HI:ST_LAT_LO];
      live_prev_r <= 7'h00;
      any_prev_r <= 1'b0;
      flt_ind_r <= 1'b0;
      tog_r <= 1'b0;
      sw_prev_r <= 1'b0;
      crc_fail_r <= 1'b0;
      boot_cnt_r <= 4'h0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= wd_r;
      end
      lat_r <= lat_nxt;
      live_prev_r <= live;
      any_prev_r <= any_fault;
      flt_ind_r <= flt_nxt;
      tog_r <= tog_nxt;
      sw_prev_r <= syn[IN_SWCLK];
      crc_fail_r <= crc_fail_r | crc_bad;
      boot_cnt_r <= boot_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hic_r <= HIC_RUN;
      hic_cnt_r <= '0;
      restart_r <= 1'b0;
    end else if (clk_en) begin
      hic_r <= hic_nxt;
      hic_cnt_r <= (hic_r == HIC_OFF) ? hic_cnt_r + HIC_CW'(1) : '0;
      restart_r <= hic_done;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_en_r <= 1'b0;
      hiz_r <= 1'b0;
      forced_pulse_mode_r <= 1'b0;
      fwd_r <= 1'b0;
      ivr_r <= 1'b0;
      refresh_r <= 1'b0;
      pg_r <= 1'b0;
    end else if (clk_en) begin
      conv_en_r <= conv_nxt;
      hiz_r <= second_overvoltage_level_ev;
      forced_pulse_mode_r <= forced_pulse_mode_mode & ~ivp_susp;
      fwd_r <= ivp_susp;
      ivr_r <= ivr_nxt;
      refresh_r <= refresh_nxt;
      pg_r <= pg_nxt;
    end
  end

  // register bus slave: address and data taken in either order
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 10'h000;
      wd_r <= 8'h00;
      wstb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[AXI_AW-1:2];
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r <= s_axi_wdata[7:0];
        wstb_r <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  // open drain: only ever pulls low
  assign fault_interrupt_pin_o = 1'b0;
  assign fault_interrupt_pin_oe = int_mode ? tog_r : flt_ind_r;
  assign converter_enable = conv_en_r;
  assign power_stage_hiz = hiz_r;
  assign forced_pulse_allow = forced_pulse_mode_r;
  assign forward_only = fwd_r;
  assign input_regulation_active = ivr_r;
  assign boot_refresh = refresh_r;
  assign power_good_mon = pg_r;
  assign hiccup_restart = restart_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_clear_read_wipes: assert property (
    clk_en & rd_clear & ~(|ev) |=> lat_r == 5'h00)
    else $error("clear read left a latched fault");
  a_w1c_status: assert property (
    clk_en & wr_status & ~(|ev) |=> (lat_r & $past(wd_r[ST_LAT_HI:ST_LAT_LO])) == 5'h00)
    else $error("status write of one did not clear");
  a_fault_sticky: assert property (
    clk_en & out_ev |=> lat_r[4] ##1 (lat_r[4] | $past(clr_all | wr_status, 1)))
    else $error("output fault not latched");
  a_current_latch: assert property (
    clk_en & cur_ev |=> lat_r[3])
    else $error("current fault not latched");
  a_avg_gate: assert property (
    clk_en & rd_fire & (ar_idx == IDX_PD_STATUS) & ~ctrl_r[CTL_AVG_EN] |=> ~s_axi_rdata[0])
    else $error("average flag high while disabled");
  a_hiz_follow: assert property (
    clk_en & second_overvoltage_level_ev |=> power_stage_hiz)
    else $error("power stage not tri-stated");
  a_crc_hold: assert property (
    crc_fail_r |-> ~converter_enable)
    else $error("converter enabled after checksum failure");
  a_int_toggle: assert property (
    clk_en & int_mode & live_change |=> fault_interrupt_pin_oe != $past(fault_interrupt_pin_oe))
    else $error("interrupt pin did not toggle");
  a_pg_gate: assert property (
    ~soft_start_done ##1 ~soft_start_done |-> ~power_good_mon)
    else $error("power good shown during soft-start");
  a_hiccup_off: assert property (
    clk_en & hic_start |=> ~converter_enable ##1 ~converter_enable)
    else $error("converter running during hiccup");
  c_hiccup_cycle: cover property (hic_done);
  c_w1c_write: cover property (wr_status & (|lat_r));
  c_crc_fail: cover property (crc_bad);
  c_int_toggle: cover property (int_mode & live_change);
endmodule

// ==== bench/fsmon_host.sv ====
`timescale 1ns/10ps
module fsmon_host (
  input wire logic ref_clk,
  output logic [fsmon_pkg::AXI_AW-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [fsmon_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  import fsmon_pkg::*;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] d, input logic [3:0] st,
                    output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge ref_clk);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ==== bench/tb_fault_status_monitor.sv ====
`timescale 1ns/10ps
module tb_fault_status_monitor;
  import fsmon_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, swclk = 1'b0, sw_run = 1'b0;
  logic [IN_W-1:0] src = '0;
  logic startup_done = 1'b0, field_busy = 1'b0, soft_start_done = 1'b0;
  logic micro_sleep = 1'b0, internal_fb_sel = 1'b0, nvm_boot_done = 1'b1;
  logic [7:0] crc_computed = 8'h5a, crc_stored = 8'h5a;
  wire pg_above = src[IN_PG], system_off = src[IN_SYS_OFF], mode_pin = src[IN_MODE];
  wire first_overvoltage_level = src[IN_FIRST_OVERVOLTAGE_LEVEL], second_overvoltage_level = src[IN_SECOND_OVERVOLTAGE_LEVEL];
  wire peak_limit_event = src[IN_PEAK], input_level_low = src[IN_VIN_LOW];
  wire thermal_shutdown = src[IN_TSD], thermal_warning = src[IN_TWARN];
  wire avg_limit_reached = src[IN_AVG], input_protection_trip = src[IN_VIN_HIGH];
  wire bootstrap_undervoltage = src[IN_BOOTSTRAP_UNDERVOLTAGE], switch_clk = swclk;
  wire [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire fault_interrupt_pin_o, fault_interrupt_pin_oe, converter_enable, power_stage_hiz;
  wire forced_pulse_allow, forward_only, input_regulation_active, boot_refresh;
  wire power_good_mon, hiccup_restart;
  // open-drain pin with pull-up
  wire fault_pin = fault_interrupt_pin_oe ? fault_interrupt_pin_o : 1'b1;
  int miscompares = 0, comparisons = 0, cyc = 0;
  logic [31:0] rdv;
  logic [1:0] rsp;
  fsmon_core dut (.*);
  fsmon_host host (.*);
  always #20 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #160 swclk <= sw_run ? ~swclk : 1'b0;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic s(input int k, input logic v);
    @(posedge ref_clk);
    src[k] <= v;
    wt(6);
  endtask
  task automatic w(input logic [9:0] i, input logic [7:0] d);
    host.wr({i, 2'b00}, d, 4'h1, rsp);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
  endtask
  task automatic r(input logic [9:0] i, input logic [7:0] e);
    host.rd({i, 2'b00}, rdv, rsp);
    chk("rdata", {24'h0, e}, rdv);
  endtask
  task automatic t_regs();
    r(IDX_CTRL, CTRL_RESET);
    r(IDX_STATUS, STATUS_RESET);
    host.rd(12'h004, rdv, rsp);
    chk("slverr", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    host.wr({IDX_CTRL, 2'b00}, 8'hff, 4'h0, rsp);
    r(IDX_CTRL, CTRL_RESET);
    w(IDX_STATUS, 8'hff);
    r(IDX_STATUS, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_latch();
    int ks[5] = '{IN_SECOND_OVERVOLTAGE_LEVEL, IN_PEAK, IN_VIN_LOW, IN_TSD, IN_TWARN};
    int bs[5] = '{5, 4, 3, 2, 2};
    for (int i = 0; i < 5; i++) begin
      s(ks[i], 1'b1);
      chb("pin_fault", 1'b0, fault_pin);
      if (ks[i] == IN_TSD) chb("conv_tsd", 1'b0, converter_enable);
      s(ks[i], 1'b0);
      chb("pin_release", 1'b1, fault_pin);
      r(IDX_STATUS, 8'h01 << bs[i]);
      case (i)
        0: w(IDX_STATUS, 8'h20);
        1: w(IDX_CLEAR, 8'h00);
        2: host.rd({IDX_CLEAR, 2'b00}, rdv, rsp);
        default: w(IDX_STATUS, 8'h3e);
      endcase
      r(IDX_STATUS, 8'h00);
    end
    chb("conv_resume", 1'b1, converter_enable);
    $display("test latch done");
  endtask
  task automatic t_live();
    @(posedge ref_clk);
    startup_done <= 1'b1;
    field_busy <= 1'b1;
    r(IDX_STATUS, 8'hc0);
    field_busy <= 1'b0;
    s(IN_PG, 1'b1);
    r(IDX_STATUS, 8'h00);
    clk_en <= 1'b0;
    s(IN_SYS_OFF, 1'b1);
    chb("frozen_conv", 1'b1, converter_enable);
    clk_en <= 1'b1;
    wt(3);
    r(IDX_STATUS, 8'h40);
    s(IN_SYS_OFF, 1'b0);
    chb("pg_early", 1'b0, power_good_mon);
    soft_start_done <= 1'b1;
    wt(3);
    chb("pg_mon", 1'b1, power_good_mon);
    $display("test live done");
  endtask
  task automatic t_first_overvoltage_level();
    soft_start_done <= 1'b0;
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b1);
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b0);
    r(IDX_STATUS, 8'h00);
    soft_start_done <= 1'b1;
    micro_sleep <= 1'b1;
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b1);
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b0);
    r(IDX_STATUS, 8'h00);
    micro_sleep <= 1'b0;
    internal_fb_sel <= 1'b1;
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b1);
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b0);
    r(IDX_STATUS, 8'h00);
    internal_fb_sel <= 1'b0;
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b1);
    chb("conv_first_overvoltage_level", 1'b1, converter_enable);
    s(IN_FIRST_OVERVOLTAGE_LEVEL, 1'b0);
    r(IDX_STATUS, 8'h20);
    w(IDX_CLEAR, 8'h00);
    $display("test first_overvoltage_level done");
  endtask
  task automatic t_ctrl();
    s(IN_SECOND_OVERVOLTAGE_LEVEL, 1'b1);
    chb("hiz", 1'b1, power_stage_hiz);
    s(IN_SECOND_OVERVOLTAGE_LEVEL, 1'b0);
    chb("hiz", 1'b0, power_stage_hiz);
    w(IDX_CTRL, 8'h02);
    s(IN_SECOND_OVERVOLTAGE_LEVEL, 1'b1);
    chb("hiz_off", 1'b0, power_stage_hiz);
    s(IN_SECOND_OVERVOLTAGE_LEVEL, 1'b0);
    w(IDX_CTRL, 8'h0e);
    s(IN_MODE, 1'b1);
    s(IN_VIN_HIGH, 1'b1);
    chb("fpa", 1'b0, forced_pulse_allow);
    chb("fwd", 1'b1, forward_only);
    s(IN_VIN_HIGH, 1'b0);
    chb("fpa", 1'b1, forced_pulse_allow);
    chb("ivr", 1'b0, input_regulation_active);
    w(IDX_CTRL, 8'h1e);
    wt(3);
    chb("ivr", 1'b1, input_regulation_active);
    s(IN_MODE, 1'b0);
    chb("ivr", 1'b0, input_regulation_active);
    s(IN_MODE, 1'b1);
    w(IDX_CTRL, 8'h16);
    wt(3);
    chb("ivr", 1'b0, input_regulation_active);
    w(IDX_CTRL, 8'h26);
    s(IN_AVG, 1'b1);
    r(IDX_PD_STATUS, 8'h01);
    w(IDX_CTRL, 8'h06);
    r(IDX_PD_STATUS, 8'h00);
    w(IDX_CLEAR, 8'h00);
    $display("test control done");
  endtask
  task automatic t_int();
    logic pv;
    w(IDX_CTRL, 8'h27);
    wt(3);
    pv = fault_pin;
    s(IN_AVG, 1'b0);
    chb("pin_toggle", ~pv, fault_pin);
    s(IN_SYS_OFF, 1'b1);
    chb("pin_toggle", pv, fault_pin);
    s(IN_SYS_OFF, 1'b0);
    w(IDX_CTRL, CTRL_RESET);
    $display("test interrupt done");
  endtask
  task automatic t_hic();
    int n;
    n = 0;
    src[IN_PEAK] <= 1'b1;
    while (!hiccup_restart && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (n == 6) src[IN_PEAK] <= 1'b0;
      if (n == 20) chb("conv_hic", 1'b0, converter_enable);
    end
    // two synchroniser edges, one decision edge, one restart register edge
    chk("hic_gap", HICCUP_OFF_CYC + 4, n);
    wt(4);
    chb("conv_back", 1'b1, converter_enable);
    w(IDX_CTRL, 8'h04);
    s(IN_PEAK, 1'b1);
    chb("conv_nohic", 1'b1, converter_enable);
    s(IN_PEAK, 1'b0);
    w(IDX_CTRL, CTRL_RESET);
    w(IDX_CLEAR, 8'h00);
    $display("test hiccup done");
  endtask
  task automatic t_end();
    src[IN_BOOTSTRAP_UNDERVOLTAGE] <= 1'b1;
    sw_run <= 1'b1;
    wt(36);
    chb("conv_uv", 1'b1, converter_enable);
    wt(48);
    chb("conv_uv", 1'b0, converter_enable);
    // power save: refresh while counting, then stop after the shorter count
    sw_run <= 1'b0;
    src[IN_BOOTSTRAP_UNDERVOLTAGE] <= 1'b0;
    s(IN_MODE, 1'b0);
    src[IN_BOOTSTRAP_UNDERVOLTAGE] <= 1'b1;
    sw_run <= 1'b1;
    wt(6);
    chb("refresh", 1'b1, boot_refresh);
    chb("conv_psm", 1'b1, converter_enable);
    wt(48);
    chb("refresh_end", 1'b0, boot_refresh);
    chb("conv_psm", 1'b0, converter_enable);
    sw_run <= 1'b0;
    src[IN_BOOTSTRAP_UNDERVOLTAGE] <= 1'b0;
    crc_stored <= 8'ha5;
    wt(4);
    r(IDX_STATUS, 8'h02);
    w(IDX_CLEAR, 8'h00);
    r(IDX_STATUS, 8'h02);
    chb("conv_crc", 1'b0, converter_enable);
    $display("test boot and checksum done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_latch();
    t_live();
    t_first_overvoltage_level();
    t_ctrl();
    t_int();
    t_hic();
    t_end();
    end_of_test();
  end
endmodule
